/* sref_pkg.sv */
// Shared constants and types for the serial receive error-flag block
package sref_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    typedef logic [DATA_W-1:0] sref_word_t;
    typedef logic [ADDR_W-1:0] sref_addr_t;

    // Register byte offsets
    localparam sref_addr_t OFF_CTRL = 8'h00;
    localparam sref_addr_t OFF_STATUS = 8'h04;
    localparam sref_addr_t OFF_DATA = 8'h08;
    localparam sref_addr_t OFF_IRQ_STAT = 8'h0c;
    localparam sref_addr_t OFF_IRQ_MASK = 8'h10;
    localparam sref_addr_t OFF_BAUD = 8'h14;

    // Control register fields
    localparam int CTRL_RX_EN = 0;
    localparam int CTRL_SYNC = 1;
    localparam int CTRL_PAR_EN = 2;
    localparam int CTRL_PAR_ODD = 3;
    localparam int CTRL_TWO_STOP = 4;
    localparam int CTRL_STANDBY = 5;
    localparam int CTRL_W = 6;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

    // Status bit positions, shared by interrupt status and mask
    localparam int ST_FULL = 6;
    localparam int ST_FRAME = 4;
    localparam int ST_PARITY = 3;
    localparam sref_word_t FLAG_BITS = 32'h0000_0058;

    // Flag indices
    localparam int NFLAGS = 3;
    localparam int FL_FULL = 0;
    localparam int FL_PARITY = 1;
    localparam int FL_FRAME = 2;
    localparam int FLAG_POS [NFLAGS] = '{ST_FULL, ST_PARITY, ST_FRAME};

    // Bit timing: 16 samples per bit, sample tick every BAUD+1 clocks
    localparam int BAUD_W = 16;
    localparam logic [BAUD_W-1:0] BAUD_RESET = 16'h0043;
    localparam logic [3:0] START_MID = 4'h7;
    localparam logic [3:0] LAST_TICK = 4'hf;
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;

    typedef enum logic [5:0]
    {
        RX_IDLE = 6'h01,
        RX_START = 6'h02,
        RX_DATA = 6'h04,
        RX_PARITY = 6'h08,
        RX_STOP1 = 6'h10,
        RX_STOP2 = 6'h20
    } sref_rx_state_t;

endpackage : sref_pkg

/* sref_rx_if.sv */
// Interface between the flag logic and the character receiver
`timescale 1ns/1ps
interface sref_rx_if;
    logic en;
    logic tick;
    logic line;
    logic par_en;
    logic par_odd;
    logic two_stop;
    logic done;
    logic [7:0] data;
    logic frame_err;
    logic par_err;

    modport ctl (output en, tick, line, par_en, par_odd, two_stop,
                 input done, data, frame_err, par_err);
    modport rcv (input en, tick, line, par_en, par_odd, two_stop,
                 output done, data, frame_err, par_err);
endinterface : sref_rx_if

/* sref_rx_frame.sv */
// Asynchronous character receiver with stop and parity checks
`timescale 1ns/1ps
module sref_rx_frame
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control and results
    sref_rx_if.rcv rx
);
    import sref_pkg::*;

    sref_rx_state_t state;
    logic [3:0] cnt;
    logic [2:0] bit_idx;
    logic [7:0] shift;
    logic sample;

    assign sample = rx.tick && (cnt == LAST_TICK);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= RX_IDLE;
            cnt <= 4'h0;
            bit_idx <= 3'h0;
            shift <= 8'h00;
            rx.done <= 1'b0;
            rx.data <= 8'h00;
            rx.frame_err <= 1'b0;
            rx.par_err <= 1'b0;
        end
        else
        begin
            rx.done <= 1'b0;
            if (rx.tick && state != RX_IDLE)
                cnt <= cnt + 4'h1;
            // Disable drops any partial character
            if (!rx.en)
                state <= RX_IDLE;
            else
            begin
                case (state)
                    RX_IDLE:
                        if (!rx.line)
                        begin
                            state <= RX_START;
                            cnt <= 4'h0;
                        end
                    RX_START:
                        if (rx.tick && cnt == START_MID)
                        begin
                            // Glitch, not a start bit
                            state <= rx.line ? RX_IDLE : RX_DATA;
                            cnt <= 4'h0;
                            bit_idx <= 3'h0;
                            rx.par_err <= 1'b0;
                        end
                    RX_DATA:
                        if (sample)
                        begin
                            shift <= {rx.line, shift[7:1]};
                            bit_idx <= bit_idx + 3'h1;
                            if (bit_idx == LAST_DATA_BIT)
                                state <= rx.par_en ? RX_PARITY : RX_STOP1;
                        end
                    RX_PARITY:
                        if (sample)
                        begin
                            rx.par_err <= ((^shift) ^ rx.line) != rx.par_odd; // [R10]
                            state <= RX_STOP1;
                        end
                    RX_STOP1:
                        if (sample)
                        begin
                            rx.done <= 1'b1;
                            rx.data <= shift;
                            rx.frame_err <= !rx.line; // [R1] [R2]
                            state <= rx.two_stop ? RX_STOP2 : RX_IDLE;
                        end
                    RX_STOP2:
                        if (sample)
                            state <= RX_IDLE; // [R3]
                    default:
                        state <= RX_IDLE;
                endcase
            end
        end
    end

endmodule : sref_rx_frame

/* sref_top.sv */
// Serial receive error flags with APB register access
//
// Behaviour
// [R1] Framing flag sets in async mode when the checked stop bit reads 0.
// [R2] Framing condition is raised during async reception as abnormal termination.
// [R3] With two stop bits only the first one is checked.
// [R4] Framing error still loads the holding buffer but not the full flag.
// [R5] Reception is halted while the framing flag is 1.
// [R6] Clocked synchronous mode halts transmission while an error flag is set.
// [R7] Reset or software standby force both error flags to 0.
// [R8] Framing flag clears only on write 0 after reading it as 1.
// [R9] Clearing the receive enable leaves the framing flag unchanged.
// [R10] Parity flag sets on parity mismatch with parity enabled in async mode.
// [R11] Parity error still loads the holding buffer but not the full flag.
// [R12] Reception is halted while the parity flag is 1.
// [R13] Parity flag clears only on write 0 after reading it as 1.
// [R14] Clearing the receive enable leaves the parity flag unchanged.
// [R15] Full flag sets only on error-free completion with buffer load.
// [R16] Software writes only 0 to the flags, only to clear them.
// [R17] Writing 1 to an error flag does not change it.
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
module sref_top
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire sref_pkg::sref_addr_t paddr,
    input wire sref_pkg::sref_word_t pwdata,
    output sref_pkg::sref_word_t prdata,
    output logic pready,
    output logic pslverr,
    // Serial line
    input wire logic rxd,
    // Status outputs
    output logic tx_halt,
    output logic irq
);
    import sref_pkg::*;

    function automatic logic hit(input sref_addr_t a, input sref_addr_t off);
        return a == off;
    endfunction : hit

    function automatic logic mapped(input sref_addr_t a);
        return hit(a, OFF_CTRL) || hit(a, OFF_STATUS) || hit(a, OFF_DATA)
            || hit(a, OFF_IRQ_STAT) || hit(a, OFF_IRQ_MASK) || hit(a, OFF_BAUD);
    endfunction : mapped

    logic [1:0] rst_pipe;
    logic rst_n;
    logic rxd_s1;
    logic rxd_s2;
    logic rxd_s3;
    logic rx_line;
    logic [BAUD_W-1:0] baud_div;
    logic [BAUD_W-1:0] baud_cnt;
    logic tick;
    logic [CTRL_W-1:0] ctrl;
    logic standby;
    logic [7:0] rx_holding_buffer;
    logic [NFLAGS-1:0] evt;
    wire [NFLAGS-1:0] flag;
    sref_word_t irq_stat;
    sref_word_t irq_mask;
    sref_word_t evt_word;
    sref_word_t status_word;
    sref_word_t next_prdata;
    sref_word_t next_irq_stat;
    logic setup;
    logic wr;
    logic rd;
    logic wr_stat;
    logic rd_stat;
    logic rd_irq;
    logic frame_fault_flag;
    logic parity_fault_flag;
    logic rx_full_flag;

    sref_rx_if rx_bus ();

    // Reset: asynchronous assert, synchronous release
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            rst_pipe <= 2'b00;
        else
            rst_pipe <= {rst_pipe[0], 1'b1};
    end

    assign rst_n = rst_pipe[1];

    // Receive pin: first stage feeds only the second
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxd_s1 <= 1'b1;
            rxd_s2 <= 1'b1;
            rxd_s3 <= 1'b1;
        end
        else
        begin
            rxd_s1 <= rxd;
            rxd_s2 <= rxd_s1;
            rxd_s3 <= rxd_s2;
        end
    end

    // Line level follows only once two stages agree
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rx_line <= 1'b1;
        else if (rxd_s2 == rxd_s3)
            rx_line <= rxd_s3;
    end

    // Oversampling tick divider
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            baud_cnt <= '0;
            tick <= 1'b0;
        end
        // Compare with >= so a divisor lowered mid-count wraps at once
        else if (baud_cnt >= baud_div)
        begin
            baud_cnt <= '0;
            tick <= 1'b1;
        end
        else
        begin
            baud_cnt <= baud_cnt + 16'h0001;
            tick <= 1'b0;
        end
    end

    // Bus decode; slave never inserts wait states
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign wr_stat = wr && hit(paddr, OFF_STATUS);
    assign rd_stat = rd && hit(paddr, OFF_STATUS);
    assign rd_irq = rd && hit(paddr, OFF_IRQ_STAT);
    assign pready = 1'b1;

    // Control register
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl <= CTRL_RESET;
        else if (wr && hit(paddr, OFF_CTRL))
            ctrl <= pwdata[CTRL_W-1:0];
    end

    assign standby = ctrl[CTRL_STANDBY];

    // Baud divisor and interrupt mask
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            baud_div <= BAUD_RESET;
            irq_mask <= '0;
        end
        else if (wr && hit(paddr, OFF_BAUD))
            baud_div <= pwdata[BAUD_W-1:0];
        else if (wr && hit(paddr, OFF_IRQ_MASK))
            irq_mask <= pwdata & FLAG_BITS;
    end

    // Receiver hookup; the enable bit gates reception only, never the flags
    assign rx_bus.en = ctrl[CTRL_RX_EN] && !ctrl[CTRL_SYNC] && !standby
        && !frame_fault_flag // [R5] [R9]
        && !parity_fault_flag; // [R12] [R14]
    assign rx_bus.tick = tick;
    assign rx_bus.line = rx_line;
    assign rx_bus.par_en = ctrl[CTRL_PAR_EN];
    assign rx_bus.par_odd = ctrl[CTRL_PAR_ODD];
    assign rx_bus.two_stop = ctrl[CTRL_TWO_STOP];

    // Receiver idles in clocked synchronous mode; flags outlive it
    sref_rx_frame u_rx
    (
        .clk(sys_clk),
        .rst_n(rst_n),
        .rx(rx_bus)
    );

    // Every finished character lands in the buffer, good or not
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rx_holding_buffer <= 8'h00;
        else if (rx_bus.done)
            rx_holding_buffer <= rx_bus.data; // [R4] [R11]
    end

    // Flag set events
    always_comb
    begin
        evt = '0;
        evt[FL_FULL] = rx_bus.done && !rx_bus.frame_err && !rx_bus.par_err; // [R15] [R4] [R11]
        evt[FL_FRAME] = rx_bus.done && rx_bus.frame_err; // [R1]
        evt[FL_PARITY] = rx_bus.done && rx_bus.par_err; // [R10]
    end

    // Flags: cleared by writing 0 after a read returned 1; set wins over clear
    for (genvar i = 0; i < NFLAGS; i++)
    begin : g_flag
        logic fl;
        logic clr;
        logic armed;

        // A clear needs a fresh read each time; arming drops after use
        assign clr = wr_stat && !pwdata[FLAG_POS[i]] && armed; // [R8] [R13] [R16] [R17]
        assign flag[i] = fl;

        always_ff @(posedge sys_clk or negedge rst_n)
        begin
            if (!rst_n)
                fl <= 1'b0; // [R7]
            else if (standby)
                fl <= 1'b0; // [R7]
            else if (evt[i])
                fl <= 1'b1;
            else if (clr)
                fl <= 1'b0;
        end

        // Arming uses the value actually returned to software
        always_ff @(posedge sys_clk or negedge rst_n)
        begin
            if (!rst_n)
                armed <= 1'b0;
            else if (standby || clr)
                armed <= 1'b0;
            else if (rd_stat && prdata[FLAG_POS[i]])
                armed <= 1'b1; // [R8] [R13]
        end
    end

    // Named views of the flag vector
    assign frame_fault_flag = flag[FL_FRAME];
    assign parity_fault_flag = flag[FL_PARITY];
    assign rx_full_flag = flag[FL_FULL];

    // Only the clocked synchronous transmitter is stopped by an error
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            tx_halt <= 1'b0;
        else
            tx_halt <= ctrl[CTRL_SYNC] && (frame_fault_flag || parity_fault_flag); // [R6]
    end

    // Status and interrupt words share one bit layout
    always_comb
    begin
        status_word = '0;
        status_word[ST_FULL] = rx_full_flag;
        status_word[ST_FRAME] = frame_fault_flag;
        status_word[ST_PARITY] = parity_fault_flag;
        evt_word = '0;
        evt_word[ST_FULL] = evt[FL_FULL];
        evt_word[ST_FRAME] = evt[FL_FRAME];
        evt_word[ST_PARITY] = evt[FL_PARITY];
    end

    // Interrupt status: read clears the bits returned, a new event wins
    always_comb
    begin
        next_irq_stat = irq_stat;
        if (rd_irq)
            next_irq_stat = irq_stat & ~prdata;
        next_irq_stat = next_irq_stat | evt_word;
    end

    // Sticky event bits, one per flag position
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_stat <= '0;
        else
            irq_stat <= next_irq_stat;
    end

    // Registered so the pin cannot glitch while the bus decodes
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(irq_stat & irq_mask);
    end

    // Read data is captured in the setup cycle so the access edge sees it stable
    always_comb
    begin
        next_prdata = '0;
        case (1'b1)
            hit(paddr, OFF_CTRL):
                next_prdata[CTRL_W-1:0] = ctrl;
            hit(paddr, OFF_STATUS):
                next_prdata = status_word;
            hit(paddr, OFF_DATA):
                next_prdata[7:0] = rx_holding_buffer;
            hit(paddr, OFF_IRQ_STAT):
                next_prdata = irq_stat;
            hit(paddr, OFF_IRQ_MASK):
                next_prdata = irq_mask;
            hit(paddr, OFF_BAUD):
                next_prdata[BAUD_W-1:0] = baud_div;
            default:
                next_prdata = '0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= pwrite ? '0 : next_prdata;
            pslverr <= !mapped(paddr);
        end
        else if (!psel)
        begin
            prdata <= '0;
            pslverr <= 1'b0;
        end
    end

endmodule : sref_top

/* sref_monitor.sv */
// Assertion checker for the serial receive error-flag block
`timescale 1ns/1ps
module sref_monitor
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire sref_pkg::sref_addr_t paddr,
    input wire sref_pkg::sref_word_t pwdata,
    input wire sref_pkg::sref_word_t prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Serial and status
    input wire logic rxd,
    input wire logic tx_halt,
    input wire logic irq
);
    import sref_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic sync_q, sby_q, keep_fr, keep_pa, last_fr, last_pa, last_full;
    wire acc = psel && penable;
    wire bad_addr = (paddr > OFF_BAUD) || (paddr[1:0] != 2'h0);
    // Flag knowledge comes only from what software has already seen
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            {sync_q, sby_q, keep_fr, keep_pa, last_fr, last_pa, last_full} <= 7'h00;
        end
        else if (acc && pwrite && paddr == OFF_CTRL)
        begin
            sync_q <= pwdata[CTRL_SYNC];
            sby_q <= pwdata[CTRL_STANDBY];
            if (pwdata[CTRL_STANDBY])
                {keep_fr, keep_pa} <= 2'h0;
        end
        else if (acc && pwrite && paddr == OFF_STATUS)
        begin
            if (!pwdata[ST_FRAME])
                keep_fr <= 1'b0;
            if (!pwdata[ST_PARITY])
                keep_pa <= 1'b0;
        end
        else if (acc && paddr == OFF_STATUS)
        begin
            {keep_fr, keep_pa} <= 2'h3;
            {last_fr, last_pa, last_full} <= {prdata[ST_FRAME], prdata[ST_PARITY], prdata[ST_FULL]};
        end
    end
    sequence s_st_rd;
        acc && !pwrite && paddr == OFF_STATUS;
    endsequence
    sequence s_err_held;
        (keep_fr && last_fr) || (keep_pa && last_pa);
    endsequence
    AST_READY_HIGH: assert property (pready)
        else $error("pready low");
    AST_SLVERR_MAP: assert property (acc |-> pslverr == bad_addr)
        else $error("pslverr does not match address map");
    AST_HALT_SYNC: assert property (
        s_st_rd ##0 (sync_q && $past(sync_q)) |-> tx_halt == (prdata[ST_FRAME] || prdata[ST_PARITY]))
        else $error("tx_halt differs from error flags in sync mode");
    AST_HALT_ASYNC: assert property (!sync_q && !$past(sync_q) |-> !tx_halt)
        else $error("tx_halt outside sync mode");
    AST_FRAME_KEEP: assert property (s_st_rd ##0 (keep_fr && last_fr) |-> prdata[ST_FRAME])
        else $error("frame flag lost without clear");
    AST_PARITY_KEEP: assert property (s_st_rd ##0 (keep_pa && last_pa) |-> prdata[ST_PARITY])
        else $error("parity flag lost without clear");
    AST_RX_BLOCKED: assert property (
        s_st_rd ##0 s_err_held ##0 !last_full |-> !prdata[ST_FULL])
        else $error("character received while error flag held");
    AST_STANDBY_CLR: assert property (
        s_st_rd ##0 (sby_q && $past(sby_q, 3)) |-> !prdata[ST_FRAME] && !prdata[ST_PARITY])
        else $error("error flag set during standby");
endmodule : sref_monitor

/* sref_line_model.sv */
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module sref_line_model
#(
    parameter int BIT_CLKS = 16
)
(
    // Clock
    input wire logic clk,
    // Serial line, idle high as with a pull-up
    output logic rxd
);
    initial rxd = 1'b1;
    task automatic bit_out(input logic v);
        rxd <= v;
        repeat (BIT_CLKS) @(posedge clk);
    endtask : bit_out
    // Second stop goes out as 0 to show it is ignored
    task automatic send(input logic [7:0] d, input logic par_on, input logic par_v,
                        input logic stop1, input logic two);
        bit_out(1'b0);
        for (int i = 0; i < 8; i++)
            bit_out(d[i]);
        if (par_on)
            bit_out(par_v);
        bit_out(stop1);
        if (two)
            bit_out(1'b0);
        bit_out(1'b1);
    endtask : send
endmodule : sref_line_model

/* sref_top_tb.sv */
// Self-checking bench for the serial receive error-flag block
`timescale 1ns/1ps
module sref_top_tb;
    import sref_pkg::*;
    logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, rxd, tx_halt, irq, err;
    sref_addr_t paddr;
    sref_word_t pwdata, prdata, rd;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    sref_top DUT (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
                  .pready, .pslverr, .rxd, .tx_halt, .irq);
    sref_line_model line (.clk(sys_clk), .rxd);
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic chk32(input sref_word_t got, input sref_word_t exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk32
    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask : chk1
    // Called right after a rising edge; one idle cycle follows each transfer
    task automatic apb(input sref_addr_t a, input logic w, input sref_word_t d);
        logic rdy;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        rdy = 1'b0;
        // Answer is taken at the rising edge where pready is seen high
        while (rdy !== 1'b1)
        begin
            @(posedge sys_clk);
            rdy = pready;
            rd = prdata;
            err = pslverr;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic wr(input sref_addr_t a, input sref_word_t d);
        apb(a, 1'b1, d);
    endtask : wr
    task automatic rd_chk(input sref_addr_t a, input sref_word_t exp);
        apb(a, 1'b0, 32'h0);
        chk32(rd, exp);
    endtask : rd_chk
    task automatic send_ch(input logic [7:0] d, input logic par_on, input logic bad_par,
                           input logic stop1, input logic two);
        line.send(d, par_on, (^d) ^ bad_par, stop1, two);
    endtask : send_ch
    task automatic wait_irq(input logic exp);
        logic seen;
        seen = 1'b0;
        for (int n = 0; n < 96 && !seen; n++)
        begin
            @(negedge sys_clk);
            seen = (irq === 1'b1);
        end
        @(posedge sys_clk);
        chk1(seen, exp);
    endtask : wait_irq
    // Registered output settles one cycle after the causing write
    task automatic halt_chk(input logic exp);
        @(negedge sys_clk);
        chk1(tx_halt, exp);
        @(posedge sys_clk);
    endtask : halt_chk
    initial
    begin
        {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd_chk(OFF_STATUS, 32'h0);
        apb(8'h40, 1'b0, 32'h0);
        chk1(err, 1'b1);
        chk32(rd, 32'h0);
        wr(OFF_BAUD, 32'h0);
        wr(OFF_IRQ_MASK, FLAG_BITS);
        wr(OFF_CTRL, 32'h5);
        send_ch(8'ha5, 1'b1, 1'b0, 1'b1, 1'b0);
        wait_irq(1'b1);
        rd_chk(OFF_IRQ_STAT, 32'h40);
        rd_chk(OFF_STATUS, 32'h40);
        rd_chk(OFF_DATA, 32'ha5);
        wr(OFF_STATUS, 32'h0);
        send_ch(8'h3c, 1'b1, 1'b1, 1'b1, 1'b0);
        wait_irq(1'b1);
        rd_chk(OFF_IRQ_STAT, 32'h08);
        rd_chk(OFF_DATA, 32'h3c);
        wr(OFF_STATUS, 32'h0);
        rd_chk(OFF_STATUS, 32'h08);
        send_ch(8'h11, 1'b1, 1'b0, 1'b1, 1'b0);
        wait_irq(1'b0);
        rd_chk(OFF_DATA, 32'h3c);
        wr(OFF_CTRL, 32'h4);
        rd_chk(OFF_STATUS, 32'h08);
        wr(OFF_STATUS, FLAG_BITS);
        rd_chk(OFF_STATUS, 32'h08);
        wr(OFF_STATUS, 32'h0);
        rd_chk(OFF_STATUS, 32'h0);
        wr(OFF_CTRL, 32'h11);
        send_ch(8'h81, 1'b0, 1'b0, 1'b1, 1'b1);
        wait_irq(1'b1);
        rd_chk(OFF_IRQ_STAT, 32'h40);
        rd_chk(OFF_STATUS, 32'h40);
        wr(OFF_STATUS, 32'h0);
        wr(OFF_CTRL, 32'h1);
        send_ch(8'h5a, 1'b0, 1'b0, 1'b0, 1'b0);
        wait_irq(1'b1);
        rd_chk(OFF_IRQ_STAT, 32'h10);
        rd_chk(OFF_DATA, 32'h5a);
        send_ch(8'h77, 1'b0, 1'b0, 1'b1, 1'b0);
        wait_irq(1'b0);
        rd_chk(OFF_DATA, 32'h5a);
        wr(OFF_CTRL, 32'h0);
        rd_chk(OFF_STATUS, 32'h10);
        wr(OFF_CTRL, 32'h2);
        halt_chk(1'b1);
        rd_chk(OFF_STATUS, 32'h10);
        wr(OFF_STATUS, 32'h0);
        halt_chk(1'b0);
        rd_chk(OFF_STATUS, 32'h0);
        // Odd parity: a correct odd parity bit raises no parity flag
        wr(OFF_CTRL, 32'hd);
        send_ch(8'h96, 1'b1, 1'b1, 1'b1, 1'b0);
        wait_irq(1'b1);
        rd_chk(OFF_IRQ_STAT, 32'h40);
        rd_chk(OFF_STATUS, 32'h40);
        rd_chk(OFF_DATA, 32'h96);
        // Masked event must stay sticky without raising the interrupt
        wr(OFF_IRQ_MASK, 32'h0);
        wr(OFF_CTRL, 32'h5);
        send_ch(8'hc3, 1'b1, 1'b1, 1'b1, 1'b0);
        wait_irq(1'b0);
        rd_chk(OFF_IRQ_STAT, 32'h08);
        wr(OFF_CTRL, 32'h20);
        halt_chk(1'b0);
        rd_chk(OFF_STATUS, 32'h0);
        print_verdict();
    end
endmodule : sref_top_tb
bind sref_top sref_monitor u_mon (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rxd, .tx_halt, .irq);
